/* cpu_regs_pkg.sv */
package cpu_regs_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_EVT_STAT = 8'h0c;
  localparam logic [7:0] OFS_EVT_MASK = 8'h10;
  // reset values
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [15:0] EVT_RST = 16'h0000;
  // status word fields
  localparam int ST_WIDTH_BIT = 15;
  localparam int ST_EDGE_BIT = 14;
  localparam int ST_GIE_BIT = 13;
  localparam logic [31:0] ST_WR_MASK = 32'h0000_7dff;
  // enable and flag layout of the low half, and the base field in the flag high half
  localparam logic [15:0] SRC_MASK = 16'h0f3f;
  localparam int SRC_TX = 4;
  localparam int SRC_RX = 5;
  localparam int SRC_TMR0 = 8;
  localparam int SRC_TMR1 = 9;
  localparam int SRC_DMA0 = 10;
  localparam int SRC_DMA1 = 11;
  localparam int BASE_LSB = 16;
  localparam int BASE_SHIFT = 8;
  // strobe control reset values, chosen by the width indicator
  localparam logic [31:0] STRB_RST_W16 = 32'h000f_0108;
  localparam logic [31:0] STRB_RST_W32 = 32'h000f_0000;
  // edge qualification time
  localparam int CLK_PERIOD_NS = 100;
  localparam int EDGE_HOLD_NS = 200;
  localparam int EDGE_HOLD_CYC = (EDGE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_FULL = 2'b01,
    FETCH_LOW = 2'b10,
    FETCH_HIGH = 2'b11
  } fetch_state_t;
endpackage

/* cpu_status_interrupt_regs.sv */
// Functional notes
// - reset clears status bits 14:0 (bit 15 follows the pin), so external interrupts start level-triggered.
// - with status bit 14 low, all four external inputs are level-triggered.
// - a long active level may register the same interrupt repeatedly.
// - with bit 14 high, an active edge must then stay active for a duration.
// - status bit 15 mirrors the program-width pin: 1 means 16-bit memory.
// - in 16-bit mode, fetch low half then high half and join them.
// - in 32-bit mode, fetch each instruction in one 32-bit read.
// - the width indicator is read-only; software writes never change it.
// - the width indicator selects reset values of both strobe control registers.
// - the low 16 enable bits gate interrupts to the CPU.
// - the high 16 enable bits gate sync events to DMA channels 0 and 1.
// - receive goes only to DMA channel 1, transmit only to channel 0.
// - reset clears the enable register and the flag register.
// - flag bit 11 is DMA channel 1 done, bit 10 channel 0 done.
// - flag upper 16 bits hold a read-write vector-table base field.
// - vector address is the base field shifted left eight plus source offset.
module cpu_status_interrupt_regs
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [3:0] external_irq_inputs_n,
  input wire logic program_width_pin,
  // on-chip interrupt events, one-cycle pulses
  input wire logic serial_tx_evt,
  input wire logic serial_rx_evt,
  input wire logic [1:0] timer_evt,
  input wire logic dma_chan0_done_flag,
  input wire logic dma_chan1_done_flag,
  // interrupt delivery
  output logic [15:0] cpu_irq_pending,
  output logic [15:0] dma0_sync_events,
  output logic [15:0] dma1_sync_events,
  output logic irq,
  // vector lookup
  input wire logic [5:0] vector_index,
  output logic [23:0] vector_addr,
  // strobe control reset values
  output logic [31:0] strobe_zero_select,
  output logic [31:0] strobe_one_select,
  // instruction fetch
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  output logic fetch_busy,
  output logic instr_valid,
  output logic [31:0] instr_word,
  output logic pmem_rd,
  output logic pmem_half,
  output logic [24:0] pmem_addr,
  input wire logic [31:0] pmem_rdata,
  input wire logic pmem_ack
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // ---------------- synchronisers ----------------
  logic [3:0] ext_s1_r, ext_s2_r, act_d_r;
  logic pw_s1_r, pw_s2_r;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_s1_r <= 4'hf;
      ext_s2_r <= 4'hf;
      act_d_r <= 4'h0;
      pw_s1_r <= 1'b0;
      pw_s2_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= external_irq_inputs_n;
      ext_s2_r <= ext_s1_r;
      act_d_r <= ~ext_s2_r;
      pw_s1_r <= program_width_pin;
      pw_s2_r <= pw_s1_r;
    end
  end

  wire [3:0] ext_act = ~ext_s2_r;
  wire width16 = pw_s2_r;

  // ---------------- registers ----------------
  logic [31:0] status_r, enable_r, flags_r;
  logic [15:0] evt_stat_r, evt_mask_r;
  wire edge_mode = status_r[ST_EDGE_BIT];
  wire global_irq_allow = status_r[ST_GIE_BIT];

  // ---------------- external interrupt qualification ----------------
  logic [3:0] edge_fire;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ext
      logic [3:0] cnt_r;
      logic armed_r;
      wire rise = ext_act[gi] & ~act_d_r[gi];
      // the edge only counts once the input has stayed active long enough
      assign edge_fire[gi] = armed_r & ext_act[gi] & (cnt_r == 4'(EDGE_HOLD_CYC - 1));
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          cnt_r <= 4'h0;
          armed_r <= 1'b0;
        end
        else if (rise)
        begin
          cnt_r <= 4'h0;
          armed_r <= 1'b1;
        end
        else if (!ext_act[gi] || edge_fire[gi])
        begin
          cnt_r <= 4'h0;
          armed_r <= 1'b0;
        end
        else if (armed_r)
          cnt_r <= cnt_r + 4'h1;
      end
    end
  endgenerate

  // level mode raises the flag on every active cycle, so re-entry can repeat
  wire [3:0] ext_hit = edge_mode ? edge_fire : ext_act;
  wire [15:0] flag_set = {4'h0, dma_chan1_done_flag, dma_chan0_done_flag, timer_evt,
                          2'b00, serial_rx_evt, serial_tx_evt, ext_hit};

  // ---------------- axi4-lite write path ----------------
  logic aw_full_r, w_full_r, bvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;

  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  wire wr_go = aw_full_r && w_full_r && !bvalid_r;
  wire [7:0] wa = {aw_addr_r[7:2], 2'b00};
  wire wr_st = wr_go && wa == OFS_STATUS;
  wire wr_ie = wr_go && wa == OFS_ENABLE;
  wire wr_if = wr_go && wa == OFS_FLAGS;
  wire wr_es = wr_go && wa == OFS_EVT_STAT;
  wire wr_em = wr_go && wa == OFS_EVT_MASK;
  wire wr_hit = wr_st | wr_ie | wr_if | wr_es | wr_em;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_r)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ---------------- register next values ----------------
  wire [31:0] st_wr = merge(status_r, w_data_r, w_strb_r) & ST_WR_MASK;
  wire [31:0] ie_wr = merge(enable_r, w_data_r, w_strb_r) & {16'hffff, SRC_MASK};
  wire [31:0] if_wr = merge(flags_r, w_data_r, w_strb_r) & {16'hffff, SRC_MASK};
  wire [31:0] es_wr = merge({16'h0, evt_stat_r}, w_data_r, w_strb_r);
  wire [31:0] em_wr = merge({16'h0, evt_mask_r}, w_data_r, w_strb_r);

  // the width bit is not stored: it is always the synchronised pin
  wire [31:0] status_nxt = wr_st ? st_wr : status_r;
  wire [31:0] enable_nxt = wr_ie ? ie_wr : enable_r;
  // a hardware set in the cycle of a software clear wins
  wire [31:0] flags_nxt = (wr_if ? if_wr : flags_r) | {16'h0, flag_set};
  wire [15:0] evt_clr = wr_es ? es_wr[15:0] : 16'h0;
  wire [15:0] evt_stat_nxt = (evt_stat_r & ~evt_clr) | flag_set;
  wire [15:0] evt_mask_nxt = wr_em ? (em_wr[15:0] & SRC_MASK) : evt_mask_r;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_r <= STATUS_RST;
      enable_r <= ENABLE_RST;
      flags_r <= FLAGS_RST;
      evt_stat_r <= EVT_RST;
      evt_mask_r <= EVT_RST;
    end
    else
    begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      flags_r <= flags_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
    end
  end

  wire [31:0] status_view = {16'h0, width16, status_r[14:0]};

  // ---------------- axi4-lite read path ----------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire rd_st = ra == OFS_STATUS;
  wire rd_ie = ra == OFS_ENABLE;
  wire rd_if = ra == OFS_FLAGS;
  wire rd_es = ra == OFS_EVT_STAT;
  wire rd_em = ra == OFS_EVT_MASK;
  wire rd_hit = rd_st | rd_ie | rd_if | rd_es | rd_em;
  wire [31:0] rd_mux = rd_st ? status_view :
                       rd_ie ? enable_r :
                       rd_if ? flags_r :
                       rd_es ? {16'h0, evt_stat_r} :
                       rd_em ? {16'h0, evt_mask_r} : 32'h0000_0000;

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ---------------- interrupt delivery ----------------
  // receive is wired only to channel 1, transmit only to channel 0
  wire [15:0] dma0_en = {4'h0, enable_r[26], 1'b0, enable_r[25], enable_r[24],
                         2'b00, 1'b0, enable_r[20], enable_r[19:16]};
  wire [15:0] dma1_en = {4'h0, 1'b0, enable_r[27], enable_r[23], enable_r[22],
                         2'b00, enable_r[21], 1'b0, enable_r[31:28]};
  wire [15:0] cpu_nxt = flags_r[15:0] & enable_r[15:0] & {16{global_irq_allow}};
  wire [23:0] vec_nxt = 24'({flags_r[31:BASE_LSB], 8'h00}) + 24'(vector_index);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_irq_pending <= 16'h0000;
      dma0_sync_events <= 16'h0000;
      dma1_sync_events <= 16'h0000;
      irq <= 1'b0;
      vector_addr <= 24'h000000;
      strobe_zero_select <= STRB_RST_W32;
      strobe_one_select <= STRB_RST_W32;
    end
    else
    begin
      cpu_irq_pending <= cpu_nxt;
      dma0_sync_events <= flags_r[15:0] & dma0_en;
      dma1_sync_events <= flags_r[15:0] & dma1_en;
      irq <= |(evt_stat_nxt & evt_mask_nxt);
      vector_addr <= vec_nxt;
      strobe_zero_select <= width16 ? STRB_RST_W16 : STRB_RST_W32;
      strobe_one_select <= width16 ? STRB_RST_W16 : STRB_RST_W32;
    end
  end

  // ---------------- instruction fetch ----------------
  fetch_state_t fst_r, fst_nxt;
  logic [23:0] faddr_r;
  logic [15:0] low_half_r;
  logic ivalid_r;
  logic [31:0] iword_r;

  always_comb
  begin
    fst_nxt = fst_r;
    case (fst_r)
      FETCH_IDLE:
        if (fetch_req)
          fst_nxt = width16 ? FETCH_LOW : FETCH_FULL;
      FETCH_FULL:
        if (pmem_ack)
          fst_nxt = FETCH_IDLE;
      FETCH_LOW:
        if (pmem_ack)
          fst_nxt = FETCH_HIGH;
      FETCH_HIGH:
        if (pmem_ack)
          fst_nxt = FETCH_IDLE;
      default:
        fst_nxt = FETCH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fst_r <= FETCH_IDLE;
      faddr_r <= 24'h000000;
      low_half_r <= 16'h0000;
      ivalid_r <= 1'b0;
      iword_r <= 32'h0000_0000;
    end
    else
    begin
      fst_r <= fst_nxt;
      ivalid_r <= 1'b0;
      if (fst_r == FETCH_IDLE && fetch_req)
        faddr_r <= fetch_addr;
      if (fst_r == FETCH_LOW && pmem_ack)
        low_half_r <= pmem_rdata[15:0];
      if (fst_r == FETCH_HIGH && pmem_ack)
      begin
        ivalid_r <= 1'b1;
        iword_r <= {pmem_rdata[15:0], low_half_r};
      end
      if (fst_r == FETCH_FULL && pmem_ack)
      begin
        ivalid_r <= 1'b1;
        iword_r <= pmem_rdata;
      end
    end
  end

  assign fetch_busy = fst_r != FETCH_IDLE;
  assign pmem_rd = fst_r != FETCH_IDLE;
  assign pmem_half = fst_r == FETCH_LOW || fst_r == FETCH_HIGH;
  assign pmem_addr = pmem_half ? {faddr_r, fst_r == FETCH_HIGH} : {1'b0, faddr_r};
  assign instr_valid = ivalid_r;
  assign instr_word = iword_r;

endmodule

/* cpu_regs_properties.sv */
module cpu_regs_checker
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // watched outputs and pins
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic program_width_pin,
  input wire logic [15:0] cpu_irq_pending,
  input wire logic [15:0] dma0_sync_events,
  input wire logic [15:0] dma1_sync_events,
  input wire logic irq,
  input wire logic [31:0] strobe_zero_select,
  input wire logic [31:0] strobe_one_select,
  input wire logic instr_valid,
  input wire logic pmem_rd,
  input wire logic pmem_half,
  input wire logic [24:0] pmem_addr,
  input wire logic pmem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  chk_reset_clear: assert property ($rose(reset_n) |-> cpu_irq_pending == 16'h0000 && !irq)
    else $error("delivery outputs not clear after reset");
  // the pin crosses two sync stages and one output register; count only out of reset
  chk_strobe_w16: assert property ((reset_n && program_width_pin) [*4] |->
    strobe_zero_select == STRB_RST_W16 && strobe_one_select == STRB_RST_W16)
    else $error("strobe reset values wrong for narrow memory");
  chk_strobe_w32: assert property ((reset_n && !program_width_pin) [*4] |->
    strobe_zero_select == STRB_RST_W32 && strobe_one_select == STRB_RST_W32)
    else $error("strobe reset values wrong for wide memory");
  chk_dma_route: assert property (!dma0_sync_events[SRC_RX] && !dma1_sync_events[SRC_TX])
    else $error("serial event offered to the wrong dma channel");
  chk_cpu_layout: assert property ((cpu_irq_pending & ~SRC_MASK) == 16'h0000)
    else $error("unused cpu pending bit set");
  chk_half_order: assert property (pmem_rd && pmem_half && pmem_ack && !pmem_addr[0] |=>
    pmem_rd && pmem_half && !instr_valid && pmem_addr == $past(pmem_addr) + 25'h0000001)
    else $error("high half not fetched right after low half");
  chk_fetch_done: assert property (pmem_rd && pmem_ack && (!pmem_half || pmem_addr[0]) |->
    ##[1:2] instr_valid)
    else $error("instruction not delivered after last read");
  chk_full_hold: assert property (pmem_rd && !pmem_half && !pmem_ack |=>
    pmem_rd && $stable(pmem_addr))
    else $error("full width read dropped before answer");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");

  cover property (irq);
  cover property (pmem_rd && pmem_half && pmem_ack && pmem_addr[0]);
  cover property (dma1_sync_events != 16'h0000);
endmodule

bind cpu_status_interrupt_regs cpu_regs_checker chk_i (
  .mclk, .reset_n, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .program_width_pin,
  .cpu_irq_pending, .dma0_sync_events, .dma1_sync_events, .irq, .strobe_zero_select,
  .strobe_one_select, .instr_valid, .pmem_rd, .pmem_half, .pmem_addr, .pmem_ack
);

/* pmem_model.sv */
module pmem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // program memory side
  input wire logic pmem_rd,
  input wire logic [24:0] pmem_addr,
  input wire logic [1:0] wait_cyc,
  output logic [31:0] pmem_rdata,
  output logic pmem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_r;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= 2'h0;
      pmem_ack <= 1'b0;
      pmem_rdata <= 32'h0000_0000;
    end
    else if (pmem_rd && !pmem_ack && cnt_r == wait_cyc)
    begin
      pmem_ack <= 1'b1;
      pmem_rdata <= {pmem_addr[15:0] ^ 16'hc3c3, pmem_addr[15:0] ^ 16'h3c3c};
    end
    else
    begin
      pmem_ack <= 1'b0;
      // data is good only in the ack cycle, so scramble it afterwards
      pmem_rdata <= ~pmem_rdata;
      cnt_r <= (pmem_rd && !pmem_ack) ? cnt_r + 2'h1 : 2'h0;
    end
  end
endmodule

/* tb.sv */
module tb;
  import cpu_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, program_width_pin = 1'b1, fetch_req = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] external_irq_inputs_n = 4'hf;
  logic [5:0] ev = 6'h00, vector_index = 6'h00;
  logic [23:0] fetch_addr = 24'h00_0000;
  logic [1:0] wt = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic fetch_busy, instr_valid, pmem_rd, pmem_half, pmem_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, strobe_zero_select, strobe_one_select, instr_word, pmem_rdata;
  logic [15:0] cpu_irq_pending, dma0_sync_events, dma1_sync_events;
  logic [23:0] vector_addr;
  logic [24:0] pmem_addr;
  int miscompares = 0, n_checks = 0, cyc = 0;

  cpu_status_interrupt_regs dut (
    .mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_irq_inputs_n, .program_width_pin,
    .serial_tx_evt(ev[0]), .serial_rx_evt(ev[1]), .timer_evt(ev[3:2]),
    .dma_chan0_done_flag(ev[4]), .dma_chan1_done_flag(ev[5]), .cpu_irq_pending,
    .dma0_sync_events, .dma1_sync_events, .irq, .vector_index, .vector_addr,
    .strobe_zero_select, .strobe_one_select, .fetch_req, .fetch_addr, .fetch_busy,
    .instr_valid, .instr_word, .pmem_rd, .pmem_half, .pmem_addr, .pmem_rdata, .pmem_ack
  );
  pmem_model mem (.mclk, .reset_n, .pmem_rd, .pmem_addr, .wait_cyc(wt), .pmem_rdata, .pmem_ack);

  initial
  begin
    forever #50 mclk = ~mclk;
  end

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
    idle(3);
  endtask

  task automatic fetch(input logic [23:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge mclk);
    fetch_addr <= a;
    fetch_req <= 1'b1;
    @(posedge mclk);
    fetch_req <= 1'b0;
    @(posedge mclk);
    chk({31'h0, fetch_busy}, 32'h0000_0001);
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!instr_valid && n < 50);
    chk({31'h0, instr_valid}, 32'h0000_0001);
    chk(instr_word, exp);
  endtask

  task automatic t_reset;
    // the width pin needs its two sync stages before status bit 15 shows it
    idle(3);
    axr(OFS_STATUS, 32'h0000_8000);
    axr(OFS_ENABLE, ENABLE_RST);
    axr(OFS_FLAGS, FLAGS_RST);
    chk(strobe_zero_select, STRB_RST_W16);
    axw(OFS_STATUS, 32'hffff_ffff);
    axr(OFS_STATUS, 32'h0000_fdff);
    program_width_pin <= 1'b0;
    idle(5);
    axr(OFS_STATUS, 32'h0000_7dff);
    chk(strobe_one_select, STRB_RST_W32);
    axw(OFS_STATUS, 32'h0000_0000);
    axw(OFS_ENABLE, 32'hffff_ffff);
    axr(OFS_ENABLE, 32'hffff_0f3f);
    axw(8'h14, 32'h0000_0001, RESP_SLVERR);
    axr(8'h14, 32'h0000_0000, RESP_SLVERR);
    $display("reset and access test done");
  endtask

  task automatic t_events;
    axw(OFS_FLAGS, 32'h0100_0000);
    vector_index <= 6'h05;
    axr(OFS_FLAGS, 32'h0100_0000);
    chk({8'h00, vector_addr}, 32'h0001_0005);
    axw(OFS_STATUS, 32'h0000_2000);
    pulse(5);
    chk({16'h0000, cpu_irq_pending}, 32'h0000_0800);
    chk({dma0_sync_events, dma1_sync_events}, 32'h0800_0000);
    pulse(1);
    pulse(0);
    pulse(2);
    pulse(3);
    chk({dma0_sync_events, dma1_sync_events}, 32'h0b10_0320);
    chk({16'h0000, cpu_irq_pending}, 32'h0000_0b30);
    axr(OFS_FLAGS, 32'h0100_0b30);
    axw(OFS_STATUS, 32'h0000_0000);
    idle(3);
    chk({16'h0000, cpu_irq_pending}, 32'h0000_0000);
    axw(OFS_EVT_MASK, 32'h0000_0000);
    axw(OFS_EVT_STAT, 32'h0000_ffff);
    pulse(4);
    chk({31'h0, irq}, 32'h0000_0000);
    axw(OFS_EVT_MASK, 32'h0000_ffff);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0001);
    axw(OFS_EVT_STAT, 32'h0000_ffff);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0000);
    // a reset in mid-run must drop the status, enable and flag values written so far
    @(posedge mclk);
    reset_n <= 1'b0;
    idle(2);
    @(posedge mclk);
    reset_n <= 1'b1;
    axr(OFS_STATUS, STATUS_RST);
    axr(OFS_ENABLE, ENABLE_RST);
    axr(OFS_FLAGS, FLAGS_RST);
    $display("event delivery test done");
  endtask

  task automatic t_ext;
    axw(OFS_FLAGS, 32'h0000_0000);
    external_irq_inputs_n[0] <= 1'b0;
    idle(6);
    axw(OFS_FLAGS, 32'h0000_0000);
    axr(OFS_FLAGS, 32'h0000_0001);
    external_irq_inputs_n[0] <= 1'b1;
    idle(4);
    axw(OFS_STATUS, 32'h0000_4000);
    axw(OFS_FLAGS, 32'h0000_0000);
    external_irq_inputs_n[1] <= 1'b0;
    @(posedge mclk);
    external_irq_inputs_n[1] <= 1'b1;
    idle(6);
    axr(OFS_FLAGS, 32'h0000_0000);
    external_irq_inputs_n[1] <= 1'b0;
    idle(8);
    axr(OFS_FLAGS, 32'h0000_0002);
    axw(OFS_FLAGS, 32'h0000_0000);
    idle(4);
    axr(OFS_FLAGS, 32'h0000_0000);
    external_irq_inputs_n[1] <= 1'b1;
    axw(OFS_STATUS, 32'h0000_0000);
    $display("external interrupt test done");
  endtask

  task automatic t_fetch;
    fetch(24'h12_3456, 32'hf795_086a);
    wt <= 2'h3;
    fetch(24'h00_0001, 32'hc3c2_3c3d);
    program_width_pin <= 1'b1;
    idle(5);
    fetch(24'h00_1234, 32'h1855_1854);
    wt <= 2'h0;
    fetch(24'h7f_ffff, 32'hc3c3_c3c2);
    $display("fetch test done");
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_events;
    t_ext;
    t_fetch;
    wrap_up;
  end
endmodule
